/* File: rtl/uart_fifo_ctrl_irq_status.sv */
`include "uart_fifo_ctrl_map.svh"
`default_nettype none
module uart_fifo_ctrl_irq_status (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  tx_fifo_count,
  input  wire logic [4:0]  rx_fifo_count,
  input  wire logic        rx_timeout,
  input  wire logic        line_status_event,
  input  wire logic        thr_empty,
  input  wire logic        modem_status_event,
  input  wire logic        xoff_detected,
  input  wire logic        xon_received,
  input  wire logic        flow_change_event,
  input  wire logic        efr_enable,
  input  wire logic        ier_rx_data,
  input  wire logic        ier_thr,
  input  wire logic        ier_line,
  input  wire logic        ier_modem,
  input  wire logic        ier_xoff,
  input  wire logic        ier_flow,
  output logic             fifo_enable,
  output logic             dma_mode,
  output logic [4:0]       rx_trigger_level,
  output logic             tx_flush,
  output logic             rx_flush,
  output logic             transmit_dma_request_n,
  output logic             receive_dma_request_n,
  output logic             irq
);

  function automatic logic [4:0] trigger_of(input logic [1:0] field);
    case (field)
      2'h0:    trigger_of = `UFC_TRIG_00;
      2'h1:    trigger_of = `UFC_TRIG_01;
      2'h2:    trigger_of = `UFC_TRIG_10;
      default: trigger_of = `UFC_TRIG_11;
    endcase
  endfunction

  function automatic logic [5:0] code_of(input uart_fifo_ctrl_pkg::irq_source_t src);
    case (src)
      uart_fifo_ctrl_pkg::SRC_LINE:    code_of = `UFC_CODE_LINE;
      uart_fifo_ctrl_pkg::SRC_RXDATA:  code_of = `UFC_CODE_RXDATA;
      uart_fifo_ctrl_pkg::SRC_TIMEOUT: code_of = `UFC_CODE_TMO;
      uart_fifo_ctrl_pkg::SRC_THR:     code_of = `UFC_CODE_THR;
      uart_fifo_ctrl_pkg::SRC_MODEM:   code_of = `UFC_CODE_MODEM;
      uart_fifo_ctrl_pkg::SRC_XOFF:    code_of = `UFC_CODE_XOFF;
      uart_fifo_ctrl_pkg::SRC_FLOW:    code_of = `UFC_CODE_FLOW;
      default:                         code_of = `UFC_CODE_NONE;
    endcase
  endfunction

  logic        fifo_en_r;
  logic        dma_r;
  logic [1:0]  trig_field_r;
  logic        tx_flush_r;
  logic        rx_flush_r;
  logic        line_pend_r;
  logic        tmo_pend_r;
  logic        thr_pend_r;
  logic        modem_pend_r;
  logic        xoff_pend_r;
  logic        flow_pend_r;
  logic        thr_empty_q_r;
  logic        rx_hold_r;
  logic [31:0] prdata_r;
  logic        err_r;
  uart_fifo_ctrl_pkg::irq_source_t read_src_r;
  uart_fifo_ctrl_pkg::irq_source_t cur_src;
  logic        rx_level_hit;
  logic        rx_data_pend;
  logic [7:0]  isr_value;
  logic        setup_ph;
  logic        access_ph;
  logic        fcr_wr;
  logic        isr_rd;
  logic        hit_isr;
  logic        hit_fcr;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_isr   = (paddr == `UFC_ISR_OFS);
  assign hit_fcr   = (paddr == `UFC_FCR_OFS);
  assign fcr_wr    = access_ph & pwrite & hit_fcr;
  assign isr_rd    = access_ph & ~pwrite & hit_isr;

  // FIFO control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fifo_en_r    <= 1'b0;
      dma_r        <= 1'b0;
      trig_field_r <= 2'h0;
    end else if (fcr_wr) begin
      fifo_en_r <= pwdata[`UFC_FCR_EN];
      if (pwdata[`UFC_FCR_EN]) begin
        dma_r        <= pwdata[`UFC_FCR_DMA];
        trig_field_r <= pwdata[`UFC_FCR_TRG_HI:`UFC_FCR_TRG_LO];
      end
    end
  end

  // Flush bits exist only as one-cycle strobes, so they always read back clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_flush_r <= 1'b0;
      rx_flush_r <= 1'b0;
    end else begin
      tx_flush_r <= fcr_wr & pwdata[`UFC_FCR_EN] & pwdata[`UFC_FCR_TXF];
      rx_flush_r <= fcr_wr & pwdata[`UFC_FCR_EN] & pwdata[`UFC_FCR_RXF];
    end
  end

  assign fifo_enable      = fifo_en_r;
  assign dma_mode         = dma_r;
  assign rx_trigger_level = trigger_of(trig_field_r);
  assign tx_flush         = tx_flush_r;
  assign rx_flush         = rx_flush_r;

  // Level compare, so the FIFO may fill past the trigger and stay raised
  assign rx_level_hit = fifo_en_r ? (rx_fifo_count >= trigger_of(trig_field_r))
                                  : (rx_fifo_count != 5'h00);
  assign rx_data_pend = rx_level_hit;

  // Receive request latch for block mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_hold_r <= 1'b0;
    end else if (rx_fifo_count == 5'h00 || rx_flush_r) begin
      rx_hold_r <= 1'b0;
    end else if (rx_level_hit || rx_timeout) begin
      rx_hold_r <= 1'b1;
    end
  end

  always_comb begin
    if (fifo_en_r && dma_r) begin
      transmit_dma_request_n = (tx_fifo_count == `UFC_FIFO_DEPTH);
      receive_dma_request_n  = ~(rx_hold_r | ((rx_level_hit | rx_timeout) & (rx_fifo_count != 5'h00)));
    end else begin
      transmit_dma_request_n = (tx_fifo_count != 5'h00);
      receive_dma_request_n  = (rx_fifo_count == 5'h00);
    end
  end

  // Sticky sources; a set in the same cycle as the read clear wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      thr_empty_q_r <= 1'b0;
    end else begin
      thr_empty_q_r <= thr_empty;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_pend_r  <= 1'b0;
      tmo_pend_r   <= 1'b0;
      thr_pend_r   <= 1'b0;
      modem_pend_r <= 1'b0;
      flow_pend_r  <= 1'b0;
    end else begin
      line_pend_r  <= line_status_event | (line_pend_r &
                      ~(isr_rd && read_src_r == uart_fifo_ctrl_pkg::SRC_LINE));
      tmo_pend_r   <= rx_timeout | (tmo_pend_r & ~rx_flush_r &
                      ~(isr_rd && read_src_r == uart_fifo_ctrl_pkg::SRC_TIMEOUT));
      thr_pend_r   <= (thr_empty & ~thr_empty_q_r) | (thr_pend_r & thr_empty &
                      ~(isr_rd && read_src_r == uart_fifo_ctrl_pkg::SRC_THR));
      modem_pend_r <= modem_status_event | (modem_pend_r &
                      ~(isr_rd && read_src_r == uart_fifo_ctrl_pkg::SRC_MODEM));
      flow_pend_r  <= flow_change_event | (flow_pend_r &
                      ~(isr_rd && read_src_r == uart_fifo_ctrl_pkg::SRC_FLOW));
    end
  end

  // Xoff is not read-cleared: only an Xon ends it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xoff_pend_r <= 1'b0;
    end else if (xoff_detected) begin
      xoff_pend_r <= 1'b1;
    end else if (xon_received) begin
      xoff_pend_r <= 1'b0;
    end
  end

  // Fixed priority chain over enabled sources
  always_comb begin
    if (ier_line && line_pend_r) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_LINE;
    end else if (ier_rx_data && rx_data_pend) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_RXDATA;
    end else if (ier_rx_data && tmo_pend_r) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_TIMEOUT;
    end else if (ier_thr && thr_pend_r) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_THR;
    end else if (ier_modem && modem_pend_r) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_MODEM;
    end else if (efr_enable && ier_xoff && xoff_pend_r) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_XOFF;
    end else if (efr_enable && ier_flow && flow_pend_r) begin
      cur_src = uart_fifo_ctrl_pkg::SRC_FLOW;
    end else begin
      cur_src = uart_fifo_ctrl_pkg::SRC_NONE;
    end
  end

  assign isr_value = {fifo_en_r, fifo_en_r, code_of(cur_src)};
  assign irq       = (cur_src != uart_fifo_ctrl_pkg::SRC_NONE);

  // Read data is frozen at setup so the cleared source matches what was returned
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r   <= 32'h0000_0000;
      read_src_r <= uart_fifo_ctrl_pkg::SRC_NONE;
      err_r      <= 1'b0;
    end else if (setup_ph) begin
      err_r      <= ~(hit_isr | hit_fcr);
      read_src_r <= (hit_isr && !pwrite) ? cur_src : uart_fifo_ctrl_pkg::SRC_NONE;
      prdata_r   <= (hit_isr && !pwrite) ? {24'h00_0000, isr_value} : 32'h0000_0000;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = access_ph;
  assign pslverr = access_ph & err_r;

  tx_block_full_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fifo_en_r && dma_r) |-> (transmit_dma_request_n == (tx_fifo_count == `UFC_FIFO_DEPTH)))
    else $error("transmit request pin wrong in block mode");

  rx_block_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fifo_en_r && dma_r && rx_hold_r && rx_fifo_count != 5'h00) |-> !receive_dma_request_n)
    else $error("receive request released before FIFO empty");

  tx_flush_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fcr_wr && pwdata[`UFC_FCR_EN] && pwdata[`UFC_FCR_TXF]) |=> tx_flush ##1 !tx_flush)
    else $error("transmit flush not a single pulse");

  rx_flush_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fcr_wr && pwdata[`UFC_FCR_EN] && pwdata[`UFC_FCR_RXF]) |=> rx_flush ##1 !rx_flush)
    else $error("receive flush not a single pulse");

  fifo_en_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    fcr_wr |=> (fifo_enable == $past(pwdata[`UFC_FCR_EN])))
    else $error("FIFO enable did not follow write");

  gated_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fcr_wr && !pwdata[`UFC_FCR_EN]) |=> ($stable(dma_mode) && $stable(rx_trigger_level) && !tx_flush && !rx_flush))
    else $error("control bits changed without FIFO enable");

  trigger_map_a: assert property (@(posedge clk) disable iff (!rst_b)
    rx_trigger_level == ((trig_field_r == 2'h0) ? 5'h01 : (trig_field_r == 2'h1) ? 5'h04 :
                         (trig_field_r == 2'h2) ? 5'h08 : 5'h0E))
    else $error("trigger level decode wrong");

  line_first_a: assert property (@(posedge clk) disable iff (!rst_b)
    (setup_ph && !pwrite && hit_isr && ier_line && line_pend_r) |=> (prdata[5:0] == 6'h06))
    else $error("line status not reported first");

  read_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    (isr_rd && read_src_r == uart_fifo_ctrl_pkg::SRC_MODEM && !modem_status_event) |=> !modem_pend_r)
    else $error("reported modem interrupt not cleared");

  enh_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
    !efr_enable |-> (isr_value[5:4] == 2'h0))
    else $error("enhanced status bits set while disabled");

  xoff_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (xoff_pend_r && !xon_received) |=> xoff_pend_r)
    else $error("Xoff status dropped without Xon");

  fifo_bits_a: assert property (@(posedge clk) disable iff (!rst_b)
    isr_value[7:6] == {2{fifo_enable}})
    else $error("FIFO enabled bits wrong");

  irq_status_a: assert property (@(posedge clk) disable iff (!rst_b)
    irq == !isr_value[0])
    else $error("interrupt output disagrees with status bit 0");

  rx_withdraw_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fifo_en_r && rx_fifo_count < rx_trigger_level && cur_src == uart_fifo_ctrl_pkg::SRC_RXDATA) |-> 1'b0)
    else $error("receive data interrupt shown below trigger");

  irq_line_pend_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ier_line && line_pend_r) |-> irq)
    else $error("interrupt output low with line status pending");

  xoff_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cur_src == uart_fifo_ctrl_pkg::SRC_XOFF) |-> (isr_value[5:0] == 6'h10))
    else $error("Xoff status code wrong");

  flow_code_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cur_src == uart_fifo_ctrl_pkg::SRC_FLOW) |-> (isr_value[5:0] == 6'h20))
    else $error("flow change status code wrong");

  modem_gated_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ier_modem |-> (cur_src != uart_fifo_ctrl_pkg::SRC_MODEM))
    else $error("disabled modem source selected");

endmodule
`default_nettype wire

/* File: rtl/uart_fifo_ctrl_map.svh */
`ifndef UART_FIFO_CTRL_MAP_SVH
`define UART_FIFO_CTRL_MAP_SVH
`define UFC_ISR_OFS     12'h000
`define UFC_FCR_OFS     12'h004
`define UFC_FCR_EN      0
`define UFC_FCR_RXF     1
`define UFC_FCR_TXF     2
`define UFC_FCR_DMA     3
`define UFC_FCR_TRG_LO  6
`define UFC_FCR_TRG_HI  7
`define UFC_FIFO_DEPTH  5'h10
`define UFC_TRIG_00     5'h01
`define UFC_TRIG_01     5'h04
`define UFC_TRIG_10     5'h08
`define UFC_TRIG_11     5'h0E
`define UFC_CODE_NONE   6'h01
`define UFC_CODE_LINE   6'h06
`define UFC_CODE_RXDATA 6'h04
`define UFC_CODE_TMO    6'h0C
`define UFC_CODE_THR    6'h02
`define UFC_CODE_MODEM  6'h00
`define UFC_CODE_XOFF   6'h10
`define UFC_CODE_FLOW   6'h20
`endif

/* File: rtl/uart_fifo_ctrl_pkg.sv */
`default_nettype none
package uart_fifo_ctrl_pkg;
  typedef enum logic [2:0] {
    SRC_NONE    = 3'h0,
    SRC_LINE    = 3'h1,
    SRC_RXDATA  = 3'h2,
    SRC_TIMEOUT = 3'h3,
    SRC_THR     = 3'h4,
    SRC_MODEM   = 3'h5,
    SRC_XOFF    = 3'h6,
    SRC_FLOW    = 3'h7
  } irq_source_t;
endpackage
`default_nettype wire

/* File: tb/host_bus_model.sv */
`default_nettype none
module host_bus_model (
  input  wire logic        clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Leading edge wait keeps back-to-back calls from assigning psel twice
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit here: only the bench watchdog may end a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, rx_timeout, thr_empty, efr_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [4:0]  tx_fifo_count, rx_fifo_count, rx_trigger_level;
  logic        line_status_event, modem_status_event, xoff_detected, xon_received, flow_change_event;
  logic        ier_rx_data, ier_thr, ier_line, ier_modem, ier_xoff, ier_flow;
  logic        fifo_enable, dma_mode, tx_flush, rx_flush, transmit_dma_request_n, receive_dma_request_n, irq;
  int          n_errors, checks;
  logic [4:0]  lv [4];
  host_bus_model host_u (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  uart_fifo_ctrl_irq_status dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_fifo_count(tx_fifo_count), .rx_fifo_count(rx_fifo_count), .rx_timeout(rx_timeout),
    .line_status_event(line_status_event), .thr_empty(thr_empty), .modem_status_event(modem_status_event),
    .xoff_detected(xoff_detected), .xon_received(xon_received), .flow_change_event(flow_change_event),
    .efr_enable(efr_enable), .ier_rx_data(ier_rx_data), .ier_thr(ier_thr), .ier_line(ier_line),
    .ier_modem(ier_modem), .ier_xoff(ier_xoff), .ier_flow(ier_flow), .fifo_enable(fifo_enable),
    .dma_mode(dma_mode), .rx_trigger_level(rx_trigger_level), .tx_flush(tx_flush), .rx_flush(rx_flush),
    .transmit_dma_request_n(transmit_dma_request_n), .receive_dma_request_n(receive_dma_request_n), .irq(irq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        e;
    host_u.xfer(1'b0, a, 32'h0, d, e);
    chk("prdata", exp, d);
    chk("pslverr", {31'h0, exp_err}, {31'h0, e});
  endtask
  task automatic wr_fc(input logic [7:0] v);
    logic [31:0] d;
    logic        e;
    host_u.xfer(1'b1, 12'h004, {24'h0, v}, d, e);
    // Register update lands at the access edge, so step past it
    #1;
  endtask
  function automatic logic [31:0] ctl;
    return {25'h0, fifo_enable, dma_mode, rx_trigger_level};
  endfunction
  function automatic logic [31:0] pins;
    return {30'h0, transmit_dma_request_n, receive_dma_request_n};
  endfunction
  // Counts settle, timeout held one cycle, then checked off the edge
  task automatic setc(input logic [4:0] t, input logic [4:0] r, input logic to);
    @(posedge clk);
    tx_fifo_count <= t;
    rx_fifo_count <= r;
    rx_timeout <= to;
    @(posedge clk);
    rx_timeout <= 1'b0;
    #1;
  endtask
  // Bits: thr_empty, line, modem, xoff, xon, flow; thr_empty stays as set
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    {thr_empty, line_status_event, modem_status_event, xoff_detected, xon_received, flow_change_event} <= m;
    @(posedge clk);
    {line_status_event, modem_status_event, xoff_detected, xon_received, flow_change_event} <= 5'h00;
  endtask
  task automatic t_reset;
    rd(12'h000, 32'h01, 1'b0);
    chk("control", 32'h01, ctl());
    rd(12'h004, 32'h00, 1'b0);
    rd(12'h008, 32'h00, 1'b1);
  endtask
  task automatic t_control;
    wr_fc(8'hC8);
    chk("control", 32'h01, ctl());
    for (int i = 0; i < 4; i++) begin
      wr_fc({i[1:0], 6'h09});
      chk("control", {25'h0, 2'b11, lv[i]}, ctl());
    end
    rd(12'h000, 32'hC1, 1'b0);
  endtask
  task automatic t_flush;
    wr_fc(8'h07);
    #1 chk("flush", 32'h3, {30'h0, tx_flush, rx_flush});
    @(posedge clk);
    #1 chk("flush", 32'h0, {30'h0, tx_flush, rx_flush});
    wr_fc(8'h06);
    #1 chk("flush", 32'h0, {30'h0, tx_flush, rx_flush});
    chk("control", 32'h01, ctl());
    rd(12'h000, 32'h01, 1'b0);
  endtask
  task automatic t_dma;
    wr_fc(8'h49);
    setc(5'h10, 5'h00, 1'b0);
    chk("pins", 32'h3, pins());
    setc(5'h0F, 5'h03, 1'b0);
    chk("pins", 32'h1, pins());
    setc(5'h0F, 5'h04, 1'b0);
    chk("pins", 32'h0, pins());
    setc(5'h0F, 5'h02, 1'b0);
    chk("pins", 32'h0, pins());
    setc(5'h00, 5'h00, 1'b0);
    chk("pins", 32'h1, pins());
    setc(5'h00, 5'h01, 1'b1);
    chk("pins", 32'h0, pins());
    setc(5'h00, 5'h00, 1'b0);
  endtask
  task automatic t_prio;
    wr_fc(8'h03);
    setc(5'h02, 5'h01, 1'b0);
    chk("pins", 32'h2, pins());
    pulse(6'b111000);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd(12'h000, 32'hC6, 1'b0);
    rd(12'h000, 32'hC4, 1'b0);
    setc(5'h00, 5'h00, 1'b0);
    chk("pins", 32'h1, pins());
    rd(12'h000, 32'hC2, 1'b0);
    rd(12'h000, 32'hC0, 1'b0);
    rd(12'h000, 32'hC1, 1'b0);
    #1 chk("irq", 32'h0, {31'h0, irq});
    setc(5'h00, 5'h00, 1'b1);
    rd(12'h000, 32'hCC, 1'b0);
    @(posedge clk);
    ier_modem <= 1'b0;
    pulse(6'b001000);
    rd(12'h000, 32'hC1, 1'b0);
    @(posedge clk);
    ier_modem <= 1'b1;
    rd(12'h000, 32'hC0, 1'b0);
    wr_fc(8'h41);
    setc(5'h00, 5'h03, 1'b0);
    rd(12'h000, 32'hC1, 1'b0);
    setc(5'h00, 5'h05, 1'b0);
    rd(12'h000, 32'hC4, 1'b0);
    setc(5'h00, 5'h03, 1'b0);
    rd(12'h000, 32'hC1, 1'b0);
  endtask
  task automatic t_enh;
    pulse(6'b000101);
    rd(12'h000, 32'hD0, 1'b0);
    rd(12'h000, 32'hD0, 1'b0);
    pulse(6'b000010);
    rd(12'h000, 32'hE0, 1'b0);
    rd(12'h000, 32'hC1, 1'b0);
    @(posedge clk);
    efr_enable <= 1'b0;
    pulse(6'b000101);
    rd(12'h000, 32'hC1, 1'b0);
  endtask
  initial begin
    lv = '{5'h01, 5'h04, 5'h08, 5'h0E};
    {rx_timeout, thr_empty, tx_fifo_count, rx_fifo_count} = 12'h000;
    {line_status_event, modem_status_event, xoff_detected, xon_received, flow_change_event} = 5'h00;
    {ier_rx_data, ier_thr, ier_line, ier_modem, ier_xoff, ier_flow, efr_enable} = 7'h7F;
    rst_b = 1'b0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_control();
    t_flush();
    t_dma();
    t_prio();
    t_enh();
    end_sim();
  end
  // Whole run needs well under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
